// ==== rtl/cpu_bus_data_channel.sv ====
// data channel between the system controller and the processor bus
// assumes fwd_clock_reset_in and wr_mode_in come from logic on sys_clk_in;
// pad inversion of the active-low pins and tristate resolution live outside
// What this block does
// - every 64-bit quadword travels with 8 check bits, both directions
// - read data drives the data bus aligned with the four outbound clocks
// - check bits are driven with each read quadword on the same clocks
// - check bits are captured on each inbound clock edge and passed on
// - write data is captured on both inbound clock edges and passed on
// - data and check lines float while reset is asserted
// - processor drives the lines for writes, this block for reads
// - between transfers the last sent values keep being driven
// - each outbound clock times 16 data and 2 check bits, both edges
// - outbound clocks idle in clock-forward reset, run after three clocks
// - data valid paces read quadword pairs, any idle gap allowed
// - data valid is aligned with the command forwarded clock
// - reference clock of 66.67, 100 or 133.33 MHz is accepted
`timescale 1ns/1ps
module cpu_bus_data_channel
  import fsb_data_pkg::*;
#(
  parameter int REF_CLOCK_KHZ = REF_KHZ_MID
) (
  input  wire logic              sys_clk_in,
  input  wire logic              srst_in,
  input  wire logic              fwd_clock_reset_in,
  input  wire logic              wr_mode_in,
  input  wire quad_t             rd_word_in,
  input  wire logic              rd_valid_in,
  output logic                   rd_ready_out,
  output quad_t                  wr_word_out,
  output logic                   wr_valid_out,
  input  wire logic [DATA_W-1:0] cpu_data_bus_in,
  output logic      [DATA_W-1:0] cpu_data_bus_out,
  output logic                   cpu_data_bus_oe_n_out,
  input  wire logic [CHK_W-1:0]  cpu_check_bits_in,
  output logic      [CHK_W-1:0]  cpu_check_bits_out,
  output logic                   cpu_check_bits_oe_n_out,
  output logic      [LANES-1:0]  read_fwd_clocks_out,
  input  wire logic [LANES-1:0]  write_fwd_clocks_in,
  output logic                   read_data_valid_out,
  output logic                   cmd_in_fwd_clock_out,
  output logic                   ref_clock_ok_out
);

  // outbound clock generation
  logic [1:0] start_cnt;
  logic       running;
  logic [2:0] div_cnt;
  wire        clk_hold = srst_in || fwd_clock_reset_in;
  wire        tick     = running && (div_cnt == HALF_LAST);
  wire        rise_tick = tick && !read_fwd_clocks_out[0];

  always_ff @(posedge sys_clk_in) begin
    if (clk_hold) begin
      start_cnt <= 2'h0;
      running   <= 1'b0;
    end else if (!running) begin
      start_cnt <= start_cnt + 2'h1;
      running   <= (start_cnt == START_LAST);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!running) begin
      div_cnt <= 3'h0;
    end else begin
      div_cnt <= tick ? 3'h0 : div_cnt + 3'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (clk_hold || !running) begin
      read_fwd_clocks_out  <= '0;
      cmd_in_fwd_clock_out <= 1'b0;
    end else if (tick) begin
      read_fwd_clocks_out  <= ~read_fwd_clocks_out;
      cmd_in_fwd_clock_out <= ~cmd_in_fwd_clock_out;
    end
  end

  // two-entry read buffer
  quad_t      buf_mem [BUF_DEPTH];
  logic       wr_ptr;
  logic       rd_ptr;
  logic [1:0] count;
  tx_state_t  tx_state;
  wire quad_t head     = buf_mem[rd_ptr];
  wire        push     = rd_valid_in && rd_ready_out;
  // a pair starts only when both quadwords are in hand, so no bubble splits it
  wire        launch_a = rise_tick && (tx_state == TX_HOLD) && (count == BUF_FULL)
                         && !wr_mode_in;
  wire        launch_b = tick && (tx_state == TX_SECOND);
  wire        pop      = launch_a || launch_b;
  wire [1:0]  next_count = count + {1'b0, push} - {1'b0, pop};

  always_ff @(posedge sys_clk_in) begin
    if (push) begin
      buf_mem[wr_ptr] <= rd_word_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      wr_ptr       <= 1'b0;
      rd_ptr       <= 1'b0;
      count        <= 2'h0;
      rd_ready_out <= 1'b0;
    end else begin
      wr_ptr       <= wr_ptr ^ push;
      rd_ptr       <= rd_ptr ^ pop;
      count        <= next_count;
      rd_ready_out <= (next_count != BUF_FULL);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      tx_state <= TX_HOLD;
    end else begin
      unique case (tx_state)
        TX_HOLD:   if (launch_a) tx_state <= TX_SECOND;
        TX_SECOND: if (launch_b) tx_state <= TX_HOLD;
      endcase
    end
  end

  // valid moves on command clock edges
  always_ff @(posedge sys_clk_in) begin
    if (srst_in || clk_hold) begin
      read_data_valid_out <= 1'b0;
    end else if (rise_tick) begin
      read_data_valid_out <= launch_a;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cpu_data_bus_out   <= '0;
      cpu_check_bits_out <= '0;
    end else if (pop) begin
      cpu_data_bus_out   <= head.data;
      cpu_check_bits_out <= head.check;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cpu_data_bus_oe_n_out   <= 1'b1;
      cpu_check_bits_oe_n_out <= 1'b1;
    end else begin
      cpu_data_bus_oe_n_out   <= wr_mode_in;
      cpu_check_bits_oe_n_out <= wr_mode_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      ref_clock_ok_out <= 1'b0;
    end else begin
      ref_clock_ok_out <= ref_rate_ok(REF_CLOCK_KHZ);
    end
  end

  // receive side: every pin passes two flops; clocks get a third for edges
  logic [LANES-1:0]  wclk_meta;
  logic [LANES-1:0]  wclk_sync;
  logic [LANES-1:0]  wclk_prev;
  quad_t             din_meta;
  quad_t             din_sync;
  quad_t             cap;
  logic [LANES-1:0]  lane_got;
  logic [DATA_W-1:0] next_data;
  logic [CHK_W-1:0]  next_chk;
  wire               rx_on = wr_mode_in && !fwd_clock_reset_in;
  wire [LANES-1:0]   wedge = (wclk_sync ^ wclk_prev) & {LANES{rx_on}};
  wire [LANES-1:0]   next_got = lane_got | wedge;
  wire               rx_done = &next_got;

  always_ff @(posedge sys_clk_in) begin
    wclk_meta <= write_fwd_clocks_in;
    wclk_sync <= wclk_meta;
    wclk_prev <= wclk_sync;
    din_meta  <= {cpu_data_bus_in, cpu_check_bits_in};
    din_sync  <= din_meta;
  end

  for (genvar i = 0; i < LANES; i++) begin : g_lane
    assign next_data[i*LANE_DATA_W +: LANE_DATA_W] = wedge[i] ?
        din_sync.data[i*LANE_DATA_W +: LANE_DATA_W] : cap.data[i*LANE_DATA_W +: LANE_DATA_W];
    assign next_chk[i*LANE_CHK_W +: LANE_CHK_W] = wedge[i] ?
        din_sync.check[i*LANE_CHK_W +: LANE_CHK_W] : cap.check[i*LANE_CHK_W +: LANE_CHK_W];
  end

  // word assembly; lanes that lag a whole edge would merge wrongly
  always_ff @(posedge sys_clk_in) begin
    if (srst_in) begin
      cap          <= '0;
      lane_got     <= '0;
      wr_word_out  <= '0;
      wr_valid_out <= 1'b0;
    end else begin
      cap          <= {next_data, next_chk};
      lane_got     <= rx_done ? '0 : next_got;
      wr_valid_out <= rx_done;
      if (rx_done) begin
        wr_word_out <= {next_data, next_chk};
      end
    end
  end

  default clocking cb @(posedge sys_clk_in); endclocking
  default disable iff (srst_in);

  float_reset_a: assert property (disable iff (1'b0)
    srst_in |=> cpu_data_bus_oe_n_out && cpu_check_bits_oe_n_out)
    else $error("bus driven during reset");
  release_write_a: assert property (wr_mode_in |=> cpu_data_bus_oe_n_out
    && cpu_check_bits_oe_n_out)
    else $error("bus driven during write");
  fwd_hold_a: assert property (fwd_clock_reset_in |=>
    (read_fwd_clocks_out == 4'h0) && !cmd_in_fwd_clock_out)
    else $error("forwarded clock ran in clock reset");
  fwd_start_a: assert property ($fell(fwd_clock_reset_in) |->
    (read_fwd_clocks_out == 4'h0) [*4] ##[1:4] (read_fwd_clocks_out == 4'hf))
    else $error("forwarded clock start delay wrong");
  lanes_aligned_a: assert property ((read_fwd_clocks_out == 4'h0) ||
    (read_fwd_clocks_out == 4'hf))
    else $error("forwarded clock lanes split");
  pair_valid_a: assert property ($rose(read_data_valid_out) |->
    read_data_valid_out [*8])
    else $error("valid dropped inside a pair");
  valid_cmd_clk_a: assert property ($changed(read_data_valid_out) |->
    $changed(cmd_in_fwd_clock_out))
    else $error("valid not aligned with command clock");
  launch_word_a: assert property (launch_a |=>
    (cpu_data_bus_out == $past(head.data)) && (cpu_check_bits_out == $past(head.check)))
    else $error("launched word mismatch");
  hold_value_a: assert property (!pop |=> $stable(cpu_data_bus_out) &&
    $stable(cpu_check_bits_out))
    else $error("bus value moved between transfers");
  capture_check_a: assert property (wedge[1] |=>
    cap.check[3:2] == $past(din_sync.check[3:2]))
    else $error("check bits not captured");
  write_pulse_a: assert property (rx_done |=> wr_valid_out &&
    (wr_word_out == $past({next_data, next_chk})) ##1 (lane_got == 4'h0 || !wr_valid_out))
    else $error("write word not delivered");

  wr_once_a: assert property (wr_valid_out |=> !wr_valid_out)
    else $error("write pulse longer than one cycle");

  rx_idle_a: assert property (!rx_on |=> !wr_valid_out)
    else $error("write word while receive is off");

  drive_read_a: assert property (!wr_mode_in |=> !cpu_data_bus_oe_n_out
    && !cpu_check_bits_oe_n_out)
    else $error("lines floated in read mode");

  ready_full_a: assert property ((count == BUF_FULL) |-> !rd_ready_out)
    else $error("ready while buffer full");

  valid_launch_a: assert property ($rose(read_data_valid_out) |->
    $past(launch_a))
    else $error("valid raised without a pair");

  fwd_period_a: assert property ($changed(read_fwd_clocks_out[0]) |=>
    $stable(read_fwd_clocks_out[0]) [*3])
    else $error("forwarded clock half period short");

  ref_ok_a: assert property (!srst_in |=>
    ref_clock_ok_out == ref_rate_ok(REF_CLOCK_KHZ))
    else $error("reference rate flag wrong");

  reset_values_a: assert property (disable iff (1'b0) srst_in |=>
    !read_data_valid_out && !wr_valid_out && !rd_ready_out)
    else $error("reset values wrong");

  for (genvar i = 0; i < LANES; i++) begin : g_lane_chk
    lane_data_a: assert property (@(posedge sys_clk_in) disable iff (srst_in)
      wedge[i] |=> (cap.data[i*LANE_DATA_W +: LANE_DATA_W]
      == $past(din_sync.data[i*LANE_DATA_W +: LANE_DATA_W])))
      else $error("lane data slice not captured");
  end

  pair_sent_c: cover property (launch_a ##[1:8] launch_b);
  write_word_c: cover property (wr_valid_out);
  fwd_release_c: cover property ($fell(fwd_clock_reset_in) ##[1:12] read_fwd_clocks_out[0]);
  back_to_back_c: cover property (launch_b ##4 launch_a);
  lane_split_c: cover property (wedge[0] && !wedge[3]);

endmodule : cpu_bus_data_channel

// ==== rtl/fsb_data_pkg.sv ====
// constants and types for the processor-side data channel
// assumes a single 100 MHz core clock; all link pins are sampled or driven from it
package fsb_data_pkg;
  localparam int CLK_MHZ       = 100;
  localparam int FWD_HALF_NS   = 40;
  localparam int FWD_HALF_CYC  = (FWD_HALF_NS * CLK_MHZ) / 1000;
  localparam int FWD_START_DLY = 3;
  localparam int LANES         = 4;
  localparam int LANE_DATA_W   = 16;
  localparam int LANE_CHK_W    = 2;
  localparam int DATA_W        = 64;
  localparam int CHK_W         = 8;
  localparam int BUF_DEPTH     = 2;
  localparam int REF_KHZ_LOW   = 66670;
  localparam int REF_KHZ_MID   = 100000;
  localparam int REF_KHZ_HIGH  = 133330;

  localparam logic [2:0] HALF_LAST  = 3'(FWD_HALF_CYC - 1);
  localparam logic [1:0] START_LAST = 2'(FWD_START_DLY - 1);
  localparam logic [1:0] BUF_FULL   = 2'(BUF_DEPTH);

  typedef struct packed {
    logic [DATA_W-1:0] data;
    logic [CHK_W-1:0]  check;
  } quad_t;

  typedef enum logic [1:0] {
    TX_HOLD   = 2'b01,
    TX_SECOND = 2'b10
  } tx_state_t;

  function automatic logic ref_rate_ok(input int khz);
    return (khz == REF_KHZ_LOW) || (khz == REF_KHZ_MID) || (khz == REF_KHZ_HIGH);
  endfunction : ref_rate_ok
endpackage : fsb_data_pkg

// ==== testbench/cpu_proc_model.sv ====
// processor model: forwards write clocks and drives write data
// assumes the bench calls send_word only inside a frame
`timescale 1ns/1ps
module cpu_proc_model
  import fsb_data_pkg::*;
(
  output logic [LANES-1:0]  write_fwd_clocks_out,
  output logic [DATA_W-1:0] data_out,
  output logic [CHK_W-1:0]  check_out
);
  initial begin
    write_fwd_clocks_out = '0;
    data_out             = '0;
    check_out            = '0;
  end
  task automatic send_word(input quad_t w);
    data_out             = w.data;
    check_out            = w.check;
    write_fwd_clocks_out = ~write_fwd_clocks_out;
    #40;
  endtask : send_word
  // one lane at a time; only the toggling lane's slice is true
  task automatic send_staggered(input quad_t w);
    quad_t m;
    for (int i = 0; i < LANES; i++) begin
      m = ~w;
      m.data[i*LANE_DATA_W +: LANE_DATA_W] = w.data[i*LANE_DATA_W +: LANE_DATA_W];
      m.check[i*LANE_CHK_W +: LANE_CHK_W]  = w.check[i*LANE_CHK_W +: LANE_CHK_W];
      data_out                = m.data;
      check_out               = m.check;
      write_fwd_clocks_out[i] = ~write_fwd_clocks_out[i];
      #20;
    end
  endtask : send_staggered
  task automatic release_lines();
    data_out  = ~data_out;
    check_out = ~check_out;
  endtask : release_lines
endmodule : cpu_proc_model

// ==== testbench/cpu_bus_data_channel_tb.sv ====
// self-checking bench for the processor-side data channel
// assumes the processor model is the only source of write clocks
`timescale 1ns/1ps
module cpu_bus_data_channel_tb;
  import fsb_data_pkg::*;
  logic              sys_clk_in = 1'b0;
  logic              srst_in = 1'b1;
  logic              fwd_rst = 1'b1;
  logic              wr_mode = 1'b0;
  logic              rd_valid = 1'b0;
  quad_t             rd_word = '0;
  quad_t             wr_word, w, last;
  logic              rd_ready, wr_valid, d_oe_n, c_oe_n, dval, cmd_clk, ref_ok, prev_cmd;
  logic [DATA_W-1:0] bus_in, bus_out;
  logic [CHK_W-1:0]  chk_in, chk_out;
  logic [LANES-1:0]  wclk, rclk, prev_rclk;
  quad_t             rd_q[$];
  quad_t             wr_q[$];
  int                n_mismatch = 0;
  int                n_tests = 0;
  int                seed = 32'h2dc90c06;
  int                k, p;

  always #5 sys_clk_in = ~sys_clk_in;

  cpu_bus_data_channel DUT (
    .sys_clk_in(sys_clk_in), .srst_in(srst_in), .fwd_clock_reset_in(fwd_rst),
    .wr_mode_in(wr_mode), .rd_word_in(rd_word), .rd_valid_in(rd_valid),
    .rd_ready_out(rd_ready), .wr_word_out(wr_word), .wr_valid_out(wr_valid),
    .cpu_data_bus_in(bus_in), .cpu_data_bus_out(bus_out),
    .cpu_data_bus_oe_n_out(d_oe_n), .cpu_check_bits_in(chk_in),
    .cpu_check_bits_out(chk_out), .cpu_check_bits_oe_n_out(c_oe_n),
    .read_fwd_clocks_out(rclk), .write_fwd_clocks_in(wclk),
    .read_data_valid_out(dval), .cmd_in_fwd_clock_out(cmd_clk),
    .ref_clock_ok_out(ref_ok)
  );
  cpu_proc_model P (.write_fwd_clocks_out(wclk), .data_out(bus_in), .check_out(chk_in));

  task automatic chk(input logic ok, input string msg);
    n_tests++;
    if (ok !== 1'b1) begin
      n_mismatch++;
      $display("[ERR] %0t %s", $time, msg);
    end
  endtask : chk
  task automatic end_sim();
    $display("mismatches %0d comparisons %0d", n_mismatch, n_tests);
    if (n_mismatch == 0 && n_tests > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : end_sim
  task automatic tick(input int n);
    repeat (n) @(posedge sys_clk_in);
    #1;
  endtask : tick
  function automatic quad_t rnd_word();
    return {$random(seed), $random(seed), 8'($random(seed))};
  endfunction : rnd_word
  task automatic push(input quad_t q);
    int j;
    rd_word = q;
    for (j = 0; rd_ready !== 1'b1; j++) begin
      if (j > 300) begin
        chk(1'b0, "ready timeout");
        end_sim();
      end
      tick(1);
    end
    tick(1);
    rd_q.push_back(q);
  endtask : push

  always @(negedge sys_clk_in) begin
    if (srst_in === 1'b0) begin
      chk(rclk === 4'h0 || rclk === 4'hf, "lanes split");
      if (rclk !== prev_rclk) begin
        chk(cmd_clk !== prev_cmd, "cmd clock out of step");
        if (dval === 1'b1 && d_oe_n === 1'b0) begin
          chk(rd_q.size() > 0, "unexpected read word");
          if (rd_q.size() > 0) chk({bus_out, chk_out} === rd_q.pop_front(), "read word");
        end
      end
      if (wr_valid === 1'b1) begin
        chk(wr_q.size() > 0, "unexpected write word");
        if (wr_q.size() > 0) chk(wr_word === wr_q.pop_front(), "write word");
      end
    end
    prev_rclk = rclk;
    prev_cmd  = cmd_clk;
  end

  initial begin
    tick(5);
    chk(d_oe_n === 1'b1 && c_oe_n === 1'b1, "lines driven in reset");
    srst_in = 1'b0;
    tick(4);
    chk(rclk === 4'h0, "clocks run in fwd reset");
    chk(ref_ok === 1'b1, "ref rate refused");
    chk(d_oe_n === 1'b0 && c_oe_n === 1'b0, "read lines not driven");
    fwd_rst = 1'b0;
    for (k = 0; rclk !== 4'hf && k < 20; k++) tick(1);
    chk(k >= 4 && k <= 8, "fwd clock start delay");
    if (rclk !== 4'hf) end_sim();
    // first pairs back to back, then random idle gaps
    for (p = 0; p < 6; p++) begin
      rd_valid = 1'b1;
      push(rnd_word());
      last = rnd_word();
      push(last);
      rd_valid = 1'b0;
      tick(p < 2 ? 1 : 1 + ($random(seed) & 15));
    end
    for (k = 0; rd_q.size() > 0 && k < 300; k++) tick(1);
    chk(rd_q.size() == 0, "read words lost");
    if (rd_q.size() != 0) end_sim();
    tick(20);
    chk({bus_out, chk_out} === last && d_oe_n === 1'b0, "idle lines not held");
    // edges in read mode must be dropped
    #3;
    P.send_word(rnd_word());
    tick(4);
    wr_mode = 1'b1;
    tick(2);
    chk(d_oe_n === 1'b1 && c_oe_n === 1'b1, "lines driven in write mode");
    #3;
    for (p = 0; p < 8; p++) begin
      w = rnd_word();
      wr_q.push_back(w);
      P.send_word(w);
    end
    // lanes one at a time: a slice tied to the wrong lane shows up here
    w = rnd_word();
    wr_q.push_back(w);
    P.send_staggered(w);
    P.release_lines();
    tick(10);
    chk(wr_q.size() == 0, "write words lost");
    srst_in = 1'b1;
    wr_mode = 1'b0;
    tick(1);
    chk(d_oe_n === 1'b1 && c_oe_n === 1'b1 && rclk === 4'h0, "not floated in reset");
    end_sim();
  end
endmodule : cpu_bus_data_channel_tb
